/* File: src/spb_serial_port.sv */
// Serial port control, status, baud timing and frame shifting
// What this block does
// - Pins attach only with enable and directions
// - Async full-duplex, clocked modes half-duplex
// - Mode bit picks clocked or asynchronous
// - Clocked: master makes clock, slave takes it
// - Transmit frame nine or eight bits
// - Transmit enable; receive enables win when clocked
// - Speed bit used only when asynchronous
// - Read-only flag: transmit shifter empty
// - Ninth transmitted bit from control register
// - Transmit control bit three reads zero
// - Receive frame nine or eight bits
// - Single receive, master only, self-clearing
// - Continuous receive, wins over single receive
// - Address mode keeps frames with ninth set
// - Framing flag follows each loaded byte
// - Overrun sticks until continuous receive cleared
// - Ninth received bit stored, no parity
// - Dedicated free-running 8-bit baud timer
// - Bit period 64, 16 or 4 ticks
// - Divisor write restarts the baud timer
// - Async receive level by three-sample majority
// - Start, LSB-first data, one stop bit
// - Oversample at x16 bit rate in both speeds
//
// Implementation choice: the plain strobed port.
module spb_serial_port (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Transmit or clock pin
    input wire logic tx_clock_pin_i,
    output logic tx_clock_pin_o,
    output logic tx_clock_pin_oe_n_o,
    // Receive or data pin
    input wire logic rx_data_pin_i,
    output logic rx_data_pin_o,
    output logic rx_data_pin_oe_n_o
);

    // ************************************
    // Declarations
    // ************************************
    spb_pkg::spb_tx_ctrl_s txc_reg, txc_next;
    spb_pkg::spb_rx_ctrl_s rxc_reg, rxc_next;
    logic [7:0] baud_reg, baud_next;
    logic [1:0] dir_reg, dir_next;
    logic [7:0] txbuf_reg, txbuf_next;
    logic txfull_reg, txfull_next;
    logic [7:0] rxbuf_reg, rxbuf_next;
    logic rxfull_reg, rxfull_next;
    logic [7:0] rdata_next;
    spb_pkg::spb_tx_st_e tx_st_reg, tx_st_next;
    logic [3:0] tx_cnt_reg, tx_cnt_next;
    logic [3:0] tx_bits_reg, tx_bits_next;
    logic [8:0] tx_sh_reg, tx_sh_next;
    logic tx_line_reg, tx_line_next;
    spb_pkg::spb_rx_st_e rx_st_reg, rx_st_next;
    logic [3:0] rx_cnt_reg, rx_cnt_next;
    logic [3:0] rx_bits_reg, rx_bits_next;
    logic [8:0] rx_sh_reg, rx_sh_next;
    logic [2:0] maj_reg, maj_next;
    logic [1:0] pre_reg, pre_next;
    logic half_reg, half_next;
    logic sclk_reg, sclk_next;
    logic tck_s1, tck_s2, tck_s3, rxd_s1, rxd_s2;
    logic tck_o_next, tck_oe_n_next, dat_o_next, dat_oe_n_next;
    logic tick, baud_wr, port_on, clocked, master, rx_act, rx_en;
    logic ovs_en, clk_run, toggle, ck_rise, ck_fall, maj_bit;
    logic tx_go, tx_take, rx_done, rx_framing_error, rx_keep;
    logic [7:0] rx_byte;
    logic rx_nine;

    // ************************************
    // Mode decode
    // ************************************
    assign port_on = rxc_reg.port_en & (&dir_reg);
    assign clocked = txc_reg.clocked;
    assign master = clocked & txc_reg.clk_master;
    assign rx_act = rxc_reg.cont_rx | (rxc_reg.single_rx & master);
    assign rx_en = port_on & ~rxc_reg.overrun & (clocked ? rx_act : rxc_reg.cont_rx);
    assign baud_wr = wr_i & (addr_i == spb_pkg::BAUD_ADDR);
    assign maj_bit = (maj_reg[0] & maj_reg[1]) | (maj_reg[0] & maj_reg[2]) | (maj_reg[1] & maj_reg[2]);

    spb_baud_timer #(
        .W(8)
    ) u_timer (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .divisor_i(baud_next),
        .restart_i(baud_wr),
        .tick_o(tick)
    );

    // ************************************
    // Timing and pins
    // ************************************
    assign ovs_en = ~clocked & tick & (txc_reg.high_speed | (pre_reg == spb_pkg::LOW_PRE_LAST));
    assign clk_run = master & ((tx_st_reg == spb_pkg::TX_DATA) | (rx_st_reg == spb_pkg::RX_DATA));
    assign toggle = clk_run & tick & half_reg;
    assign ck_rise = clocked & (master ? (toggle & ~sclk_reg) : (tck_s2 & ~tck_s3));
    assign ck_fall = clocked & (master ? (toggle & sclk_reg) : (~tck_s2 & tck_s3));

    always_comb
    begin
        pre_next = tick ? pre_reg + 1'b1 : pre_reg;
        half_next = (tick & clk_run) ? ~half_reg : half_reg;
        sclk_next = toggle ? ~sclk_reg : sclk_reg;
        if (baud_wr)
        begin
            pre_next = '0;
            half_next = 1'b0;
        end
        if (!clk_run)
        begin
            sclk_next = 1'b0;
            half_next = 1'b0;
        end
        tck_o_next = clocked ? sclk_reg : tx_line_reg;
        tck_oe_n_next = ~port_on | (clocked & ~master);
        dat_o_next = tx_line_reg;
        dat_oe_n_next = ~(port_on & clocked & txc_reg.tx_en & ~rx_act);
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            pre_reg <= '0;
            half_reg <= 1'b0;
            sclk_reg <= 1'b0;
            tck_s1 <= 1'b1;
            tck_s2 <= 1'b1;
            tck_s3 <= 1'b1;
            rxd_s1 <= 1'b1;
            rxd_s2 <= 1'b1;
            tx_clock_pin_o <= 1'b1;
            tx_clock_pin_oe_n_o <= 1'b1;
            rx_data_pin_o <= 1'b1;
            rx_data_pin_oe_n_o <= 1'b1;
        end
        else
        begin
            pre_reg <= pre_next;
            half_reg <= half_next;
            sclk_reg <= sclk_next;
            tck_s1 <= tx_clock_pin_i;
            tck_s2 <= tck_s1;
            tck_s3 <= tck_s2;
            rxd_s1 <= rx_data_pin_i;
            rxd_s2 <= rxd_s1;
            tx_clock_pin_o <= tck_o_next;
            tx_clock_pin_oe_n_o <= tck_oe_n_next;
            rx_data_pin_o <= dat_o_next;
            rx_data_pin_oe_n_o <= dat_oe_n_next;
        end
    end

    // ************************************
    // Transmitter
    // ************************************
    assign tx_go = txfull_reg & txc_reg.tx_en & port_on & ~(clocked & rx_act);
    assign tx_take = (tx_st_reg == spb_pkg::TX_IDLE) & tx_go;

    always_comb
    begin
        tx_st_next = tx_st_reg;
        tx_cnt_next = ovs_en ? tx_cnt_reg + 1'b1 : tx_cnt_reg;
        tx_bits_next = tx_bits_reg;
        tx_sh_next = tx_sh_reg;
        tx_line_next = tx_line_reg;
        unique case (tx_st_reg)
            spb_pkg::TX_IDLE:
            begin
                tx_line_next = 1'b1;
                tx_cnt_next = '0;
                if (tx_go)
                begin
                    tx_sh_next = {txc_reg.ninth, txbuf_reg};
                    tx_bits_next = txc_reg.nine ? spb_pkg::BITS_NINE : spb_pkg::BITS_EIGHT;
                    tx_st_next = clocked ? spb_pkg::TX_DATA : spb_pkg::TX_START;
                    tx_line_next = clocked ? txbuf_reg[0] : 1'b0;
                end
            end
            spb_pkg::TX_START:
            begin
                if (ovs_en && tx_cnt_reg == spb_pkg::OVS_LAST)
                begin
                    tx_st_next = spb_pkg::TX_DATA;
                    tx_line_next = tx_sh_reg[0];
                end
            end
            spb_pkg::TX_DATA:
            begin
                if (clocked ? ck_fall : (ovs_en && tx_cnt_reg == spb_pkg::OVS_LAST))
                begin
                    tx_sh_next = {1'b0, tx_sh_reg[8:1]};
                    tx_bits_next = tx_bits_reg - 1'b1;
                    tx_line_next = tx_sh_reg[1];
                    if (tx_bits_reg == 4'h1)
                    begin
                        tx_st_next = clocked ? spb_pkg::TX_IDLE : spb_pkg::TX_STOP;
                        tx_line_next = 1'b1;
                    end
                end
            end
            spb_pkg::TX_STOP:
            begin
                if (ovs_en && tx_cnt_reg == spb_pkg::OVS_LAST)
                begin
                    tx_st_next = spb_pkg::TX_IDLE;
                end
            end
        endcase
        if (!port_on || (clocked && rx_act))
        begin
            tx_st_next = spb_pkg::TX_IDLE;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            tx_st_reg <= spb_pkg::TX_IDLE;
            tx_cnt_reg <= '0;
            tx_bits_reg <= '0;
            tx_sh_reg <= '0;
            tx_line_reg <= 1'b1;
        end
        else
        begin
            tx_st_reg <= tx_st_next;
            tx_cnt_reg <= tx_cnt_next;
            tx_bits_reg <= tx_bits_next;
            tx_sh_reg <= tx_sh_next;
            tx_line_reg <= tx_line_next;
        end
    end

    // ************************************
    // Receiver
    // ************************************
    always_comb
    begin
        rx_st_next = rx_st_reg;
        rx_cnt_next = ovs_en ? rx_cnt_reg + 1'b1 : rx_cnt_reg;
        rx_bits_next = rx_bits_reg;
        rx_sh_next = rx_sh_reg;
        maj_next = maj_reg;
        rx_done = 1'b0;
        rx_framing_error = 1'b0;
        if (ovs_en && rx_cnt_reg >= spb_pkg::MAJ_FIRST && rx_cnt_reg <= spb_pkg::MAJ_LAST)
        begin
            maj_next = {maj_reg[1:0], rxd_s2};
        end
        unique case (rx_st_reg)
            spb_pkg::RX_IDLE:
            begin
                rx_cnt_next = '0;
                rx_bits_next = rxc_reg.nine ? spb_pkg::BITS_NINE : spb_pkg::BITS_EIGHT;
                if (rx_en && (clocked || (ovs_en && !rxd_s2)))
                begin
                    rx_st_next = clocked ? spb_pkg::RX_DATA : spb_pkg::RX_START;
                end
            end
            spb_pkg::RX_START:
            begin
                if (ovs_en && rx_cnt_reg == spb_pkg::OVS_LAST)
                begin
                    rx_st_next = maj_bit ? spb_pkg::RX_IDLE : spb_pkg::RX_DATA;
                end
            end
            spb_pkg::RX_DATA:
            begin
                if (clocked ? ck_rise : (ovs_en && rx_cnt_reg == spb_pkg::OVS_LAST))
                begin
                    rx_sh_next = {clocked ? rxd_s2 : maj_bit, rx_sh_reg[8:1]};
                    rx_bits_next = rx_bits_reg - 1'b1;
                    if (rx_bits_reg == 4'h1)
                    begin
                        rx_st_next = clocked ? spb_pkg::RX_IDLE : spb_pkg::RX_STOP;
                        rx_done = clocked;
                    end
                end
            end
            spb_pkg::RX_STOP:
            begin
                if (ovs_en && rx_cnt_reg == spb_pkg::OVS_LAST)
                begin
                    rx_st_next = spb_pkg::RX_IDLE;
                    rx_done = 1'b1;
                    rx_framing_error = ~maj_bit;
                end
            end
        endcase
        if (!rx_en)
        begin
            rx_st_next = spb_pkg::RX_IDLE;
        end
    end

    assign rx_byte = rxc_reg.nine ? rx_sh_next[7:0] : rx_sh_next[8:1];
    assign rx_nine = rxc_reg.nine & rx_sh_next[8];
    assign rx_keep = rx_done & (clocked | ~rxc_reg.nine | ~rxc_reg.addr_det | rx_nine);

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            rx_st_reg <= spb_pkg::RX_IDLE;
            rx_cnt_reg <= '0;
            rx_bits_reg <= '0;
            rx_sh_reg <= '0;
            maj_reg <= 3'h7;
        end
        else
        begin
            rx_st_reg <= rx_st_next;
            rx_cnt_reg <= rx_cnt_next;
            rx_bits_reg <= rx_bits_next;
            rx_sh_reg <= rx_sh_next;
            maj_reg <= maj_next;
        end
    end

    // ************************************
    // Registers
    // ************************************
    always_comb
    begin
        txc_next = txc_reg;
        rxc_next = rxc_reg;
        baud_next = baud_reg;
        dir_next = dir_reg;
        txbuf_next = txbuf_reg;
        txfull_next = txfull_reg & ~tx_take;
        rxbuf_next = rxbuf_reg;
        rxfull_next = rxfull_reg;
        rdata_next = '0;
        if (wr_i)
        begin
            unique case (addr_i)
                spb_pkg::TX_CTRL_ADDR: txc_next = spb_pkg::spb_tx_ctrl_s'({wdata_i[7:4], 1'b0, wdata_i[2], 1'b0, wdata_i[0]});
                spb_pkg::RX_CTRL_ADDR:
                begin
                    rxc_next = spb_pkg::spb_rx_ctrl_s'({wdata_i[7:3], rxc_reg.frame_err, rxc_reg.overrun, rxc_reg.ninth});
                    rxc_next.overrun = rxc_reg.overrun & wdata_i[4];
                end
                spb_pkg::BAUD_ADDR: baud_next = wdata_i;
                spb_pkg::PIN_DIR_ADDR: dir_next = wdata_i[1:0];
                spb_pkg::TX_DATA_ADDR:
                begin
                    txbuf_next = wdata_i;
                    txfull_next = 1'b1;
                end
                default: ;
            endcase
        end
        if (rd_i)
        begin
            unique case (addr_i)
                spb_pkg::TX_CTRL_ADDR: rdata_next = txc_reg;
                spb_pkg::RX_CTRL_ADDR: rdata_next = rxc_reg;
                spb_pkg::BAUD_ADDR: rdata_next = baud_reg;
                spb_pkg::PIN_DIR_ADDR: rdata_next = {txfull_reg, rxfull_reg, 4'h0, dir_reg};
                spb_pkg::RX_DATA_ADDR:
                begin
                    rdata_next = rxbuf_reg;
                    rxfull_next = 1'b0;
                end
                default: rdata_next = '0;
            endcase
        end
        txc_next.shift_empty = (tx_st_next == spb_pkg::TX_IDLE);
        if (rx_done && rxc_reg.single_rx && !rxc_reg.cont_rx && master)
        begin
            rxc_next.single_rx = 1'b0;
        end
        if (rx_keep)
        begin
            if (rxfull_reg)
            begin
                rxc_next.overrun = 1'b1;
            end
            else
            begin
                rxbuf_next = rx_byte;
                rxfull_next = 1'b1;
                rxc_next.frame_err = rx_framing_error;
                rxc_next.ninth = rx_nine;
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            txc_reg <= spb_pkg::TX_CTRL_RST;
            rxc_reg <= spb_pkg::RX_CTRL_RST;
            baud_reg <= spb_pkg::BAUD_RST;
            dir_reg <= spb_pkg::PIN_DIR_RST;
            txbuf_reg <= '0;
            txfull_reg <= 1'b0;
            rxbuf_reg <= '0;
            rxfull_reg <= 1'b0;
            rdata_o <= '0;
        end
        else
        begin
            txc_reg <= txc_next;
            rxc_reg <= rxc_next;
            baud_reg <= baud_next;
            dir_reg <= dir_next;
            txbuf_reg <= txbuf_next;
            txfull_reg <= txfull_next;
            rxbuf_reg <= rxbuf_next;
            rxfull_reg <= rxfull_next;
            rdata_o <= rdata_next;
        end
    end

    // ************************************
    // Assertions
    // ************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_tx_bit3_zero: assert property (rd_i && addr_i == spb_pkg::TX_CTRL_ADDR |=> !rdata_o[3])
        else $error("transmit control bit 3 not zero");
    a_empty_flag_read: assert property (rd_i && addr_i == spb_pkg::TX_CTRL_ADDR |=>
        rdata_o[1] == ($past(tx_st_reg) == spb_pkg::TX_IDLE))
        else $error("shift empty flag wrong");
    a_pins_released: assert property (!port_on |=> tx_clock_pin_oe_n_o && rx_data_pin_oe_n_o)
        else $error("pin driven while port off");
    a_baud_restart: assert property (baud_wr && wdata_i == 8'h00 |=> !tick ##1 tick)
        else $error("baud timer not restarted");
    a_single_clears: assert property (rx_done && master && rxc_reg.single_rx && !rxc_reg.cont_rx
        && !wr_i |=> !rxc_reg.single_rx)
        else $error("single receive not cleared");
    a_overrun_holds: assert property (rxc_reg.overrun && rxc_reg.cont_rx && !(wr_i && addr_i == spb_pkg::RX_CTRL_ADDR)
        |=> rxc_reg.overrun)
        else $error("overrun cleared early");
    a_addr_filter: assert property (rx_done && !clocked && rxc_reg.nine && rxc_reg.addr_det && !rx_nine
        && !rxfull_reg && !(rd_i && addr_i == spb_pkg::RX_DATA_ADDR) |=> !rxfull_reg)
        else $error("non-address frame loaded");
    a_half_duplex: assert property (clocked && rx_act |=> rx_data_pin_oe_n_o && tx_st_reg == spb_pkg::TX_IDLE)
        else $error("transmit active during clocked receive");
    a_no_ovs_clocked: assert property (clocked |-> !ovs_en)
        else $error("oversample enable in clocked mode");

    c_async_rx: cover property (rx_keep && !clocked);
    c_async_tx: cover property (tx_st_reg == spb_pkg::TX_STOP ##1 tx_st_reg == spb_pkg::TX_IDLE);
    c_master_rx: cover property (rx_done && master);
    c_overrun: cover property ($rose(rxc_reg.overrun));

endmodule : spb_serial_port

/* File: src/spb_pkg.sv */
// Constants, field layouts and types for the serial port block
package spb_pkg;

    // ************************************
    // Register offsets
    // ************************************
    localparam logic [7:0] RX_CTRL_ADDR = 8'h18;
    localparam logic [7:0] TX_DATA_ADDR = 8'h19;
    localparam logic [7:0] RX_DATA_ADDR = 8'h1a;
    localparam logic [7:0] PIN_DIR_ADDR = 8'h87;
    localparam logic [7:0] TX_CTRL_ADDR = 8'h98;
    localparam logic [7:0] BAUD_ADDR = 8'h99;

    // ************************************
    // Reset values
    // ************************************
    localparam logic [7:0] TX_CTRL_RST = 8'h02;
    localparam logic [7:0] RX_CTRL_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [1:0] PIN_DIR_RST = 2'h0;

    // ************************************
    // Field positions
    // ************************************
    localparam int TX_UNUSED_BIT = 3;
    localparam int TX_EMPTY_BIT = 1;
    localparam int STAT_RX_FULL_BIT = 6;
    localparam int STAT_TX_FULL_BIT = 7;

    // ************************************
    // Timing counts
    // ************************************
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] MAJ_FIRST = 4'h7;
    localparam logic [3:0] MAJ_LAST = 4'h9;
    localparam logic [1:0] LOW_PRE_LAST = 2'h3;
    localparam logic [3:0] BITS_EIGHT = 4'h8;
    localparam logic [3:0] BITS_NINE = 4'h9;

    // ************************************
    // Types
    // ************************************
    typedef struct packed {
        logic clk_master;
        logic nine;
        logic tx_en;
        logic clocked;
        logic unused;
        logic high_speed;
        logic shift_empty;
        logic ninth;
    } spb_tx_ctrl_s;

    typedef struct packed {
        logic port_en;
        logic nine;
        logic single_rx;
        logic cont_rx;
        logic addr_det;
        logic frame_err;
        logic overrun;
        logic ninth;
    } spb_rx_ctrl_s;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} spb_tx_st_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spb_rx_st_e;

endpackage : spb_pkg

/* File: src/spb_baud_timer.sv */
// Free-running reloadable baud timer with one-cycle tick
module spb_baud_timer #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Control
    input wire logic [W-1:0] divisor_i,
    input wire logic restart_i,
    // Tick
    output logic tick_o
);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic tick_next;

    always_comb
    begin
        cnt_next = cnt_reg - 1'b1;
        tick_next = 1'b0;
        if (restart_i)
        begin
            cnt_next = divisor_i;
        end
        else if (cnt_reg == '0)
        begin
            cnt_next = divisor_i;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            cnt_reg <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            tick_o <= tick_next;
        end
    end

endmodule : spb_baud_timer

/* File: verification/spb_term_model.sv */
// Far-end terminal model for the asynchronous line
module spb_term_model (
    // Line from the port
    input wire logic line_i,
    // Line to the port
    output logic line_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial line_o = 1'b1;

    // ************************************
    // Frame send and receive
    // ************************************
    task automatic send_frame(input logic [8:0] d, input int nbits, input logic stop, input realtime bt);
        line_o = 1'b0;
        #bt;
        for (int i = 0; i < nbits; i++)
        begin
            line_o = d[i];
            #bt;
        end
        line_o = stop;
        #bt;
        line_o = 1'b1;
    endtask : send_frame

    task automatic recv_frame(input int nbits, input realtime bt, output logic [8:0] d, output logic stop);
        d = 9'h000;
        @(negedge line_i);
        #(bt / 2);
        for (int i = 0; i < nbits; i++)
        begin
            #bt;
            d[i] = line_i;
        end
        #bt;
        stop = line_i;
    endtask : recv_frame
endmodule : spb_term_model

/* File: verification/tb.sv */
// Self-checking bench for the serial port block
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic tx_o, tx_oe_n, rx_o, rx_oe_n, term_line;
    wire logic tx_line = tx_oe_n ? 1'b1 : tx_o;
    wire logic rx_line = rx_oe_n ? term_line : rx_o;
    int err_total = 0;
    int cmp_count = 0;

    always #12.5 sys_clk = ~sys_clk;

    spb_serial_port dut_u (.sys_clk_i(sys_clk), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .tx_clock_pin_i(tx_line), .tx_clock_pin_o(tx_o),
        .tx_clock_pin_oe_n_o(tx_oe_n), .rx_data_pin_i(rx_line), .rx_data_pin_o(rx_o),
        .rx_data_pin_oe_n_o(rx_oe_n));
    spb_term_model term_u (.line_i(tx_line), .line_o(term_line));

    // ************************************
    // Shared tasks
    // ************************************
    task automatic chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            $display("BAD %s expected %h seen %h", name, exp, seen);
            err_total++;
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), {1'b0, rdata}, {1'b0, exp});
    endtask : rchk

    task automatic rx_frame(input logic [8:0] d, input int nbits, input logic stop);
        @(negedge sys_clk);
        term_u.send_frame(d, nbits, stop, 800.0);
        repeat (40) @(posedge sys_clk);
    endtask : rx_frame

    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out

    // ************************************
    // Scenarios
    // ************************************
    task automatic t_reset();
        rchk(8'h98, 8'h02);
        rchk(8'h18, 8'h00);
        rchk(8'h99, 8'h00);
        rchk(8'h55, 8'h00);
        chk("pin oe", {7'h00, tx_oe_n, rx_oe_n}, 9'h003);
        wr_reg(8'h98, 8'h0b);
        rchk(8'h98, 8'h03);
    endtask : t_reset

    task automatic t_async_tx();
        logic [7:0] ctl [3] = '{8'h24, 8'h20, 8'h65};
        logic [7:0] div [3] = '{8'h01, 8'h00, 8'h00};
        realtime bt [3] = '{800.0, 1600.0, 400.0};
        logic [8:0] dat [3] = '{9'h0a5, 9'h03c, 9'h15a};
        logic [8:0] got;
        logic stop;
        wr_reg(8'h18, 8'h80);
        wr_reg(8'h98, 8'h24);
        chk("tx oe off", {8'h00, tx_oe_n}, 9'h001);
        wr_reg(8'h87, 8'h03);
        repeat (2) @(posedge sys_clk);
        chk("tx oe on", {8'h00, tx_oe_n}, 9'h000);
        for (int k = 0; k < 3; k++)
        begin
            wr_reg(8'h98, ctl[k]);
            fork
                term_u.recv_frame(ctl[k][6] ? 9 : 8, bt[k], got, stop);
                begin
                    wr_reg(8'h99, div[k]);
                    wr_reg(8'h19, dat[k][7:0]);
                    repeat (6) @(posedge sys_clk);
                    rchk(8'h98, ctl[k]);
                end
            join
            chk("tx data", got, dat[k]);
            chk("tx stop", {8'h00, stop}, 9'h001);
            repeat (40) @(posedge sys_clk);
            rchk(8'h98, ctl[k] | 8'h02);
        end
    endtask : t_async_tx

    task automatic t_async_rx();
        wr_reg(8'h98, 8'h04);
        wr_reg(8'h99, 8'h01);
        wr_reg(8'h18, 8'h90);
        rx_frame(9'h03c, 8, 1'b1);
        rchk(8'h87, 8'h43);
        rchk(8'h1a, 8'h3c);
        rx_frame(9'h0c3, 8, 1'b0);
        rchk(8'h18, 8'h94);
        rchk(8'h1a, 8'hc3);
        rx_frame(9'h011, 8, 1'b1);
        rchk(8'h1a, 8'h11);
        rchk(8'h18, 8'h90);
        rx_frame(9'h001, 8, 1'b1);
        rx_frame(9'h002, 8, 1'b1);
        rchk(8'h18, 8'h92);
        rchk(8'h1a, 8'h01);
        wr_reg(8'h18, 8'h80);
        rchk(8'h18, 8'h80);
        wr_reg(8'h18, 8'hd8);
        rx_frame(9'h055, 9, 1'b1);
        rchk(8'h87, 8'h03);
        rx_frame(9'h1aa, 9, 1'b1);
        rchk(8'h1a, 8'haa);
        rchk(8'h18, 8'hd9);
    endtask : t_async_rx

    task automatic t_clocked();
        realtime t0;
        logic [7:0] got;
        wr_reg(8'h18, 8'h80);
        wr_reg(8'h99, 8'h01);
        wr_reg(8'h98, 8'hb0);
        wr_reg(8'h19, 8'h96);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge tx_o);
            if (i == 1)
                chk("clk period", 9'(int'(($realtime - t0) / 25.0)), 9'h008);
            t0 = $realtime;
            got[i] = rx_o;
        end
        chk("sync data", {1'b0, got}, 9'h096);
        chk("data oe", {7'h00, tx_oe_n, rx_oe_n}, 9'h000);
        repeat (100) @(posedge sys_clk);
        wr_reg(8'h18, 8'ha0);
        repeat (80) @(posedge sys_clk);
        rchk(8'h18, 8'h80);
        rchk(8'h1a, 8'hff);
        wr_reg(8'h18, 8'h90);
        repeat (4) @(posedge sys_clk);
        chk("rx wins", {8'h00, rx_oe_n}, 9'h001);
        wr_reg(8'h98, 8'h30);
        repeat (4) @(posedge sys_clk);
        chk("slave clk", {8'h00, tx_oe_n}, 9'h001);
    endtask : t_clocked

    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst_i <= 1'b0;
        t_reset();
        t_async_tx();
        t_async_rx();
        t_clocked();
        close_out();
    end

    initial
    begin
        #2ms;
        err_total++;
        close_out();
    end
endmodule : tb
